/* include/ejib_pkg.sv */
// Purpose: Shared constants for the extended jump, increment and bit branch unit.
// Assumes: Byte wide data memory, 24-bit program counter, 64-byte register file.
// Notes:   Register file is big endian: the lowest byte index is the most significant.
package ejib_pkg;
  localparam logic [7:0]  ESC_BYTE    = 8'ha5;
  localparam logic [7:0]  OP_EXTENDED_JUMP_D   = 8'h8a;
  localparam logic [7:0]  OP_EXTENDED_JUMP_I   = 8'h89;
  localparam logic [7:0]  OP_EXTENDED_CALL    = 8'h9a;
  localparam logic [7:0]  OP_EXTENDED_RETURN     = 8'haa;
  localparam logic [7:0]  OP_INC_DIR  = 8'h05;
  localparam logic [6:0]  OP_INC_IND  = 7'h03;
  localparam logic [4:0]  OP_INC_REG  = 5'h01;
  localparam logic [7:0]  OP_INC_SZ   = 8'h0b;
  localparam logic [7:0]  OP_INC_DATA_POINTER_16 = 8'ha3;
  localparam logic [7:0]  OP_BITOP    = 8'ha9;
  localparam logic [4:0]  SUB_JB      = 5'h04;
  localparam logic [4:0]  SUB_JBC     = 5'h02;
  localparam logic [1:0]  SZ_BYTE     = 2'h0;
  localparam logic [1:0]  SZ_WORD     = 2'h1;
  localparam logic [1:0]  SZ_BAD      = 2'h2;
  localparam logic [1:0]  IMM_BAD     = 2'h3;
  localparam logic [23:0] PC_RST      = 24'h000000;
  localparam logic [15:0] SP_RST      = 16'h0007;
  localparam logic [4:0]  FLAGS_RST   = 5'h00;
  localparam int          FLAG_N      = 1;
  localparam int          FLAG_Z      = 0;
  localparam logic [5:0]  DPX_IDX     = 6'h38;
  localparam logic [5:0]  DPH_IDX     = 6'h3a;
  localparam logic [2:0]  LEN_MAX     = 3'h4;
  typedef enum logic [3:0] {
    S_FETCH = 4'h0, S_TAKE = 4'h1, S_EXEC = 4'h2, S_RD   = 4'h3, S_RDD = 4'h4,
    S_WR    = 4'h5, S_PUSH = 4'h6, S_POP  = 4'h7, S_POPD = 4'h8
  } ejib_state_t;
endpackage : ejib_pkg

/* rtl/ejib_core.sv */
// Purpose: Fetch, decode and execute extended jumps, increments and bit branches.
// Assumes: Program and data memories answer a read on the cycle after the strobe.
// Notes:   Binary versus source mode only moves which page needs the escape byte.
// Function
// RULE1 - Direct extended jump loads PC high byte then low word from bytes 2..4.
// RULE2 - Direct extended jump is 8Ah plus three address bytes; prefix only in binary.
// RULE3 - Indirect extended jump 89h loads PC from selected double-word register.
// RULE4 - Extended return pops three PC bytes and continues at that address.
// RULE5 - Return pops low, middle, high byte, stack pointer falls by three.
// RULE6 - Byte increment wraps FFh to 00h in register, direct, indirect modes.
// RULE7 - Increment of a port reads the output latch, not the pins.
// RULE8 - Direct increment is 05h plus address byte, never prefixed.
// RULE9 - Register and indirect increment: no prefix in binary, prefix in source.
// RULE10 - Sized increment adds 1, 2 or 4 to a byte, word or dword register.
// RULE11 - Sized increment 0Bh, register nibble, size bits, immediate bits.
// RULE12 - Data pointer increments modulo 2^16 with low to high byte carry.
// RULE13 - Data pointer high carry is dropped; extended upper word untouched.
// RULE14 - Bit set branch adds signed displacement to the advanced PC.
// RULE15 - Bit set branch never writes the tested bit.
// RULE16 - Extended bit set branch is A9h, 0010 0yyy, bit address, displacement.
// RULE17 - Jump-and-clear branches and clears a set bit; zero bit: nothing.
// RULE18 - Jump-and-clear of a port bit reads the output latch.
// RULE19 - Extended call pushes return address high byte first.
// RULE20 - Jumps, return and bit branches leave all flags unchanged.
`timescale 1ns/1ps
module ejib_core (
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  input  wire logic        src_mode_in,
  input  wire logic [7:0]  pmem_data_in,
  input  wire logic [7:0]  dmem_rdata_in,
  input  wire logic        rf_we_in,
  input  wire logic [5:0]  rf_addr_in,
  input  wire logic [7:0]  rf_wdata_in,
  output logic      [23:0] pmem_addr_out,
  output logic             pmem_rd_out,
  output logic      [15:0] dmem_addr_out,
  output logic      [7:0]  dmem_wdata_out,
  output logic             dmem_rd_out,
  output logic             dmem_wr_out,
  output logic             dmem_rmw_out,
  output logic      [23:0] pc_out,
  output logic      [15:0] sp_out,
  output logic      [4:0]  flags_out,
  output logic      [7:0]  rf_rdata_out,
  output logic             illegal_out
);
  // Architectural state; the register file is not reset, software preloads it.
  ejib_pkg::ejib_state_t st_q;
  logic [23:0] pc_q;
  logic [15:0] sp_q, addr_q;
  logic [7:0]  ib_q [0:3];
  logic [7:0]  regs [0:63];
  logic [7:0]  wdata_q, rfrd_q;
  logic [4:0]  flags_q;
  logic [2:0]  cnt_q, len_q;
  logic [1:0]  k_q;
  logic        esc_q, ext_q, rmw_q, bit_q, jbc_q, ill_q;

  // Opcode length; escape pages differ per mode, so ext folds mode and prefix together.
  // A sized increment is two bytes: opcode, then register nibble with size and immediate.
  // Unlisted opcodes fall to length one, so the core skips a single byte; bad 0Bh or A9h forms keep their full length.
  function automatic logic [2:0] dec_len(input logic [7:0] op, input logic ext,
                                         input logic esc);
    logic [2:0] n;
    n = 3'h1;
    if (ext && (op == ejib_pkg::OP_EXTENDED_JUMP_D || op == ejib_pkg::OP_EXTENDED_CALL ||
                op == ejib_pkg::OP_BITOP)) n = ejib_pkg::LEN_MAX;
    else if (ext && op == ejib_pkg::OP_INC_SZ) n = 3'h2;
    else if (ext && op == ejib_pkg::OP_EXTENDED_JUMP_I) n = 3'h2;
    else if (!esc && op == ejib_pkg::OP_INC_DIR) n = 3'h2;
    return n;
  endfunction : dec_len

  // Instruction classes, decoded from the buffered bytes.
  // Prefix tests use esc_q where the byte is never prefixed in either mode.
  wire [7:0] ib0    = ib_q[0];
  wire [7:0] ib1    = ib_q[1];
  wire       ext_nw = esc_q ^ src_mode_in;
  wire [2:0] len_nw = dec_len(pmem_data_in, ext_nw, esc_q);
  wire [2:0] need   = (cnt_q == 3'h0) ? len_nw : len_q;
  wire c_ejd  = ext_q && ib0 == ejib_pkg::OP_EXTENDED_JUMP_D;            // RULE2
  wire c_eji  = ext_q && ib0 == ejib_pkg::OP_EXTENDED_JUMP_I;            // RULE3
  wire c_ecl  = ext_q && ib0 == ejib_pkg::OP_EXTENDED_CALL;
  wire c_extended_return = ext_q && ib0 == ejib_pkg::OP_EXTENDED_RETURN;
  wire c_idir = !esc_q && ib0 == ejib_pkg::OP_INC_DIR;          // RULE8
  wire c_iind = !ext_q && ib0[7:1] == ejib_pkg::OP_INC_IND;     // RULE9
  wire c_ireg = !ext_q && ib0[7:3] == ejib_pkg::OP_INC_REG;     // RULE9
  wire c_isz  = ext_q && ib0 == ejib_pkg::OP_INC_SZ && ib1[3:2] != ejib_pkg::SZ_BAD
                && ib1[1:0] != ejib_pkg::IMM_BAD;               // RULE11
  wire c_idp  = !esc_q && ib0 == ejib_pkg::OP_INC_DATA_POINTER_16;
  wire c_jb   = ext_q && ib0 == ejib_pkg::OP_BITOP && ib1[7:3] == ejib_pkg::SUB_JB;  // RULE16
  wire c_jbc  = ext_q && ib0 == ejib_pkg::OP_BITOP && ib1[7:3] == ejib_pkg::SUB_JBC;
  wire c_rfw  = c_ireg || c_isz || c_idp;
  wire c_mem  = c_idir || c_iind || c_jb || c_jbc;

  // Register operand selection: byte, word or double word at a big-endian base.
  // Narrow operands sit in the top bytes of op32; s8, s16 and s32 are separate adders, one per size.
  wire [1:0] sz     = c_isz ? ib1[3:2] : (c_idp ? ejib_pkg::SZ_WORD : ejib_pkg::SZ_BYTE);
  wire [5:0] base   = c_eji  ? {ib1[7:4], 2'h0} :
                      c_idp  ? ejib_pkg::DPH_IDX :
                      c_ireg ? {3'h0, ib0[2:0]} :
                      (sz == ejib_pkg::SZ_BYTE) ? {2'h0, ib1[7:4]} :
                      (sz == ejib_pkg::SZ_WORD) ? {1'h0, ib1[7:4], 1'h0} : {ib1[7:4], 2'h0};
  wire [31:0] op32  = {regs[base], regs[base + 6'h1], regs[base + 6'h2], regs[base + 6'h3]};
  wire [31:0] imm   = c_isz ? (32'h1 << ib1[1:0]) : 32'h1;      // RULE10
  wire [7:0]  s8    = op32[31:24] + imm[7:0];                   // RULE6
  wire [15:0] s16   = op32[31:16] + imm[15:0];                  // RULE12
  wire [31:0] s32   = op32 + imm;
  wire [31:0] wr_d  = (sz == ejib_pkg::SZ_BYTE) ? {s8, 24'h0} :
                      (sz == ejib_pkg::SZ_WORD) ? {s16, 16'h0} : s32;
  wire [3:0]  wr_m  = (sz == ejib_pkg::SZ_BYTE) ? 4'h8 :
                      (sz == ejib_pkg::SZ_WORD) ? 4'hc : 4'hf;  // RULE13
  wire        wr_z  = (sz == ejib_pkg::SZ_BYTE) ? (s8 == 8'h0) :
                      (sz == ejib_pkg::SZ_WORD) ? (s16 == 16'h0) : (s32 == 32'h0);
  wire        core_we = (st_q == ejib_pkg::S_EXEC) && c_rfw;
  wire [23:0] br_pc = pc_q + {{16{ib_q[3][7]}}, ib_q[3]};       // RULE14
  wire        bit_v = dmem_rdata_in[ib1[2:0]];
  wire [7:0]  clr_v = dmem_rdata_in & ~(8'h1 << ib1[2:0]);      // RULE17
  wire [7:0]  inc8  = dmem_rdata_in + 8'h1;                     // RULE6

  // Strobes follow the state; addresses and write data come from flops.
  // Keeping address and data registered lets memory sample them half a cycle early.
  assign pmem_rd_out    = st_q == ejib_pkg::S_FETCH;
  assign pmem_addr_out  = pc_q;
  assign dmem_rd_out    = st_q == ejib_pkg::S_RD || st_q == ejib_pkg::S_POP;
  assign dmem_wr_out    = st_q == ejib_pkg::S_WR || st_q == ejib_pkg::S_PUSH;
  assign dmem_rmw_out   = st_q == ejib_pkg::S_RD && rmw_q;      // RULE7 RULE18
  assign dmem_addr_out  = addr_q;
  assign dmem_wdata_out = wdata_q;
  assign pc_out         = pc_q;
  assign sp_out         = sp_q;
  assign flags_out      = flags_q;
  assign rf_rdata_out   = rfrd_q;
  assign illegal_out    = ill_q;

  // Register file; the core's own write wins over the side port in the same cycle.
  // A side-port write in that cycle is lost, so software writes only while the core idles.
  always_ff @(posedge clk_sys_in) begin
    rfrd_q <= regs[rf_addr_in];
    if (core_we) begin
      for (int i = 0; i < 4; i++) begin
        if (wr_m[3 - i]) regs[base + 6'(i)] <= wr_d[31 - 8 * i -: 8];
      end
    end else if (rf_we_in) begin
      regs[rf_addr_in] <= rf_wdata_in;
    end
  end

  // Sequencer: fetch bytes, execute, then memory read-modify-write or stack moves.
  // Every memory read costs two states because both memories answer one cycle late; a write takes one state.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= ejib_pkg::S_FETCH;
      pc_q <= ejib_pkg::PC_RST;
      sp_q <= ejib_pkg::SP_RST;
      flags_q <= ejib_pkg::FLAGS_RST;
      addr_q <= 16'h0;
      wdata_q <= 8'h0;
      for (int i = 0; i < 4; i++) ib_q[i] <= 8'h0;
      {cnt_q, len_q, k_q} <= 8'h0;
      {esc_q, ext_q, rmw_q, bit_q, jbc_q, ill_q} <= 6'h0;
    end else begin
      ill_q <= 1'b0;
      unique case (st_q)
        ejib_pkg::S_FETCH: st_q <= ejib_pkg::S_TAKE;
        // A lone escape byte only arms the prefix; it never enters the byte buffer.
        ejib_pkg::S_TAKE: begin
          pc_q <= pc_q + 24'h1;
          st_q <= ejib_pkg::S_FETCH;
          if (cnt_q == 3'h0 && !esc_q && pmem_data_in == ejib_pkg::ESC_BYTE) begin
            esc_q <= 1'b1;
          end else begin
            ib_q[cnt_q[1:0]] <= pmem_data_in;
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h0) begin
              ext_q <= ext_nw;
              len_q <= len_nw;
            end
            if (cnt_q + 3'h1 == need) st_q <= ejib_pkg::S_EXEC;
          end
        end
        ejib_pkg::S_EXEC: begin
          cnt_q <= 3'h0;
          esc_q <= 1'b0;
          k_q <= 2'h0;
          rmw_q <= c_idir || c_iind || c_jbc;
          bit_q <= c_jb || c_jbc;
          jbc_q <= c_jbc;
          st_q <= ejib_pkg::S_FETCH;
          if (c_ejd) pc_q <= {ib1, ib_q[2], ib_q[3]};          // RULE1
          else if (c_eji) pc_q <= op32[23:0];                   // RULE3
          else if (c_ecl) begin
            addr_q <= sp_q + 16'h1;
            wdata_q <= pc_q[23:16];                             // RULE19
            sp_q <= sp_q + 16'h1;
            st_q <= ejib_pkg::S_PUSH;
          end else if (c_extended_return) begin
            addr_q <= sp_q;
            st_q <= ejib_pkg::S_POP;
          end else if (c_rfw) begin                             // RULE20
            flags_q[ejib_pkg::FLAG_N] <= wr_d[31];
            flags_q[ejib_pkg::FLAG_Z] <= wr_z;
          end else if (c_mem) begin
            addr_q <= {8'h0, c_iind ? regs[{5'h0, ib0[0]}] : (c_idir ? ib1 : ib_q[2])};
            st_q <= ejib_pkg::S_RD;
          end else ill_q <= 1'b1;
        end
        ejib_pkg::S_RD: st_q <= ejib_pkg::S_RDD;
        ejib_pkg::S_RDD: begin
          st_q <= ejib_pkg::S_FETCH;
          // Flags follow the incremented byte; bit branches leave them alone.
          if (!bit_q) begin
            wdata_q <= inc8;                                    // RULE6
            flags_q[ejib_pkg::FLAG_N] <= inc8[7];
            flags_q[ejib_pkg::FLAG_Z] <= inc8 == 8'h0;
            st_q <= ejib_pkg::S_WR;
          end else if (bit_v) begin
            pc_q <= br_pc;                                      // RULE14
            wdata_q <= clr_v;
            if (jbc_q) st_q <= ejib_pkg::S_WR;                  // RULE15 RULE17
          end
        end
        ejib_pkg::S_WR: st_q <= ejib_pkg::S_FETCH;
        // Push high byte first at rising addresses; the return then pops low first.
        ejib_pkg::S_PUSH: begin
          if (k_q == 2'h2) begin
            pc_q <= {ib1, ib_q[2], ib_q[3]};
            st_q <= ejib_pkg::S_FETCH;
          end else begin
            k_q <= k_q + 2'h1;
            addr_q <= sp_q + 16'h1;
            wdata_q <= (k_q == 2'h0) ? pc_q[15:8] : pc_q[7:0];  // RULE19
            sp_q <= sp_q + 16'h1;
          end
        end
        ejib_pkg::S_POP: st_q <= ejib_pkg::S_POPD;
        ejib_pkg::S_POPD: begin
          pc_q[8 * k_q +: 8] <= dmem_rdata_in;                  // RULE4 RULE5
          sp_q <= sp_q - 16'h1;
          addr_q <= sp_q - 16'h1;
          k_q <= k_q + 2'h1;
          st_q <= (k_q == 2'h2) ? ejib_pkg::S_FETCH : ejib_pkg::S_POP;
        end
        default: st_q <= ejib_pkg::S_FETCH;
      endcase
    end
  end

  // Checks on the documented behaviour of the instructions handled here.
  // Reset cuts every check short, so no property spans a mid-run reset.
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  a_extended_jump_pc_load: assert property ((st_q == ejib_pkg::S_EXEC && c_ejd) |=> // RULE1
    pc_q == {$past(ib1), $past(ib_q[2]), $past(ib_q[3])})
    else $error("extended jump target wrong");
  a_extended_jump_ind_pc: assert property ((st_q == ejib_pkg::S_EXEC && c_eji) |=> // RULE3
    pc_q == $past(op32[23:0])) else $error("indirect jump target wrong");
  a_extended_return_sp_net: assert property ((st_q == ejib_pkg::S_EXEC && c_extended_return) |-> ##7 // RULE5
    (sp_q == $past(sp_q, 7) - 16'h3 && st_q == ejib_pkg::S_FETCH))
    else $error("return stack pointer wrong");
  a_extended_return_lo_first: assert property ((st_q == ejib_pkg::S_POPD && k_q == 2'h0) |=> // RULE4
    pc_q[7:0] == $past(dmem_rdata_in)) else $error("return low byte wrong");
  a_inc_wrap_val: assert property ((st_q == ejib_pkg::S_RDD && !bit_q) |=> // RULE6
    (dmem_wr_out && dmem_wdata_out == $past(dmem_rdata_in) + 8'h1))
    else $error("memory increment wrong");
  a_rmw_latch_rd: assert property ((st_q == ejib_pkg::S_RD && (!bit_q || jbc_q)) // RULE7
    |-> dmem_rmw_out) else $error("read-modify-write not flagged");
  a_data_pointer_16_hi_kept: assert property ((st_q == ejib_pkg::S_EXEC && c_idp) |=> // RULE13
    ($stable(regs[ejib_pkg::DPX_IDX]) && $stable(regs[ejib_pkg::DPX_IDX + 6'h1])))
    else $error("extended pointer upper word changed");
  a_jb_no_write: assert property ((st_q == ejib_pkg::S_RDD && bit_q && !jbc_q) // RULE15
    |=> !dmem_wr_out [*2]) else $error("bit test wrote memory");
  a_jbc_zero_idle: assert property ((st_q == ejib_pkg::S_RDD && jbc_q && !bit_v) // RULE17
    |=> (!dmem_wr_out && $stable(pc_q))) else $error("clear on zero bit");
  a_push_hi_first: assert property ((st_q == ejib_pkg::S_EXEC && c_ecl) |=> // RULE19
    (dmem_wr_out && dmem_wdata_out == $past(pc_q[23:16]) && addr_q == $past(sp_q) + 16'h1))
    else $error("call push order wrong");
  a_jump_flags: assert property ((st_q == ejib_pkg::S_EXEC && // RULE20
    (c_ejd || c_eji || c_extended_return || c_jb)) |=> $stable(flags_q) [*3])
    else $error("flags changed by jump");

  // Data pointer, branch target, stack depth and refused encodings.
  a_data_pointer_16_inc_val: assert property ((st_q == ejib_pkg::S_EXEC && c_idp) |=> // RULE12
    {regs[ejib_pkg::DPH_IDX], regs[ejib_pkg::DPH_IDX + 6'h1]} ==
    $past({regs[ejib_pkg::DPH_IDX], regs[ejib_pkg::DPH_IDX + 6'h1]}) + 16'h1)
    else $error("data pointer increment wrong");
  a_jb_target_pc: assert property ((st_q == ejib_pkg::S_RDD && bit_q && bit_v) |=> // RULE14
    pc_q == $past(pc_q) + {{16{$past(ib_q[3][7])}}, $past(ib_q[3])})
    else $error("bit branch target wrong");
  a_jbc_clr_write: assert property ((st_q == ejib_pkg::S_RDD && jbc_q && bit_v) |=> // RULE17
    (dmem_wr_out && dmem_wdata_out == ($past(dmem_rdata_in) & ~(8'h1 << ib1[2:0]))))
    else $error("jump-and-clear write wrong");
  a_call_sp_net: assert property ((st_q == ejib_pkg::S_EXEC && c_ecl) |-> ##3 // RULE19
    (sp_q == $past(sp_q, 3) + 16'h3)) else $error("call stack pointer wrong");
  a_dir_esc_ill: assert property ((st_q == ejib_pkg::S_EXEC && esc_q && // RULE8
    ib0 == ejib_pkg::OP_INC_DIR) |=> illegal_out) else $error("prefixed direct increment ran");
  a_isz_bad_ill: assert property ((st_q == ejib_pkg::S_EXEC && ext_q && // RULE11
    ib0 == ejib_pkg::OP_INC_SZ && (ib1[3:2] == ejib_pkg::SZ_BAD ||
    ib1[1:0] == ejib_pkg::IMM_BAD)) |=> illegal_out) else $error("bad sized increment ran");
endmodule : ejib_core

/* dv/ejib_core_test.sv */
// Purpose: Self-checking bench for the extended jump, increment and bit branch core.
// Assumes: Bench models program and data memory with a one cycle read latency.
// Notes:   Each scenario resets the core and runs a short program from address zero.
`timescale 1ns/1ps
`define CHK(a, e) begin \
  check_count++; \
  if ((a) !== (e)) begin \
    fails++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); \
  end \
end
module ejib_core_test;
  logic        clk_sys_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        src_mode_in = 1'b0;
  logic        rf_we_in = 1'b0;
  logic [7:0]  pmem_data_in = 8'h00;
  logic [7:0]  dmem_rdata_in = 8'h00;
  logic [7:0]  rf_wdata_in = 8'h00;
  logic [5:0]  rf_addr_in = 6'h00;
  logic [23:0] pmem_addr_out, pc_out;
  logic [15:0] dmem_addr_out, sp_out;
  logic [7:0]  dmem_wdata_out, rf_rdata_out;
  logic [4:0]  flags_out;
  logic        pmem_rd_out, dmem_rd_out, dmem_wr_out, dmem_rmw_out, illegal_out;
  logic [7:0]  prog[logic [23:0]];
  logic [7:0]  dmem[0:255];
  logic [7:0]  rd_q[$];
  logic        rmw_q[$];
  int          fails = 0, check_count = 0, wr_n = 0, ill_n = 0;

  ejib_core ejib_core_i (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .src_mode_in(src_mode_in),
    .pmem_data_in(pmem_data_in), .dmem_rdata_in(dmem_rdata_in), .rf_we_in(rf_we_in),
    .rf_addr_in(rf_addr_in), .rf_wdata_in(rf_wdata_in), .pmem_addr_out(pmem_addr_out),
    .pmem_rd_out(pmem_rd_out), .dmem_addr_out(dmem_addr_out),
    .dmem_wdata_out(dmem_wdata_out), .dmem_rd_out(dmem_rd_out), .dmem_wr_out(dmem_wr_out),
    .dmem_rmw_out(dmem_rmw_out), .pc_out(pc_out), .sp_out(sp_out), .flags_out(flags_out),
    .rf_rdata_out(rf_rdata_out), .illegal_out(illegal_out)
  );

  // Free running 25 MHz clock.
  always #20 clk_sys_in = ~clk_sys_in;

  // Memories answer on the falling edge, so the core always samples settled data.
  always @(negedge clk_sys_in) begin
    pmem_data_in <= prog.exists(pmem_addr_out) ? prog[pmem_addr_out] : 8'h00;
    dmem_rdata_in <= dmem[dmem_addr_out[7:0]];
    if (dmem_rd_out) begin
      rd_q.push_back(dmem_addr_out[7:0]);
      rmw_q.push_back(dmem_rmw_out);
    end
    if (dmem_wr_out) begin
      dmem[dmem_addr_out[7:0]] <= dmem_wdata_out;
      wr_n++;
    end
    if (illegal_out) ill_n++;
  end

  // Prints the verdict and stops; also reached when a wait runs out.
  task automatic end_sim();
    if (fails == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // Loads a program at zero and resets; the register file keeps its contents.
  task automatic start(input logic src, input logic [7:0] b[$]);
    nrst_in = 1'b0;
    src_mode_in = src;
    prog.delete();
    foreach (b[i]) prog[24'(i)] = b[i];
    repeat (16) @(negedge clk_sys_in);
    `CHK({pc_out, sp_out, flags_out}, {ejib_pkg::PC_RST, ejib_pkg::SP_RST, 5'h00})
    rd_q.delete();
    rmw_q.delete();
    wr_n = 0;
    ill_n = 0;
    nrst_in = 1'b1;
  endtask : start

  // Bounded wait for the program counter; a stuck core ends the run.
  task automatic wpc(input logic [23:0] a);
    for (int n = 0; n < 300 && pc_out !== a; n++) @(negedge clk_sys_in);
    if (pc_out !== a) begin
      fails++;
      end_sim();
    end
  endtask : wpc

  // Side-port access to four register bytes, most significant byte first.
  task automatic wrf(input logic [5:0] a, input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      rf_we_in = 1'b1;
      rf_addr_in = a + 6'(i);
      rf_wdata_in = v[31-8*i -: 8];
      @(negedge clk_sys_in);
    end
    rf_we_in = 1'b0;
  endtask : wrf

  // Read data trails the address by one edge, so each byte costs one cycle.
  task automatic rrf(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < 4; i++) begin
      rf_addr_in = a + 6'(i);
      @(negedge clk_sys_in);
      v = {v[23:0], rf_rdata_out};
    end
    `CHK(v, e)
  endtask : rrf

  // A register wrap sets Z first, so a jump that touched flags would show.
  task automatic t_jmp();
    for (int m = 0; m < 2; m++) begin
      wrf(6'h00, 32'h00ff_0000);
      if (m == 0) start(1'b0, '{8'h09, 8'ha5, 8'h8a, 8'h12, 8'h34, 8'h56});
      else start(1'b1, '{8'ha5, 8'h09, 8'h8a, 8'h12, 8'h34, 8'h56});
      wpc(24'h123456);
      `CHK(flags_out, 5'h01)
      rrf(6'h00, 32'h0000_0000);
    end
  endtask : t_jmp

  // The top byte of the double-word register must be dropped.
  task automatic t_ijmp();
    wrf(6'h10, 32'h5aab_cdef);
    start(1'b1, '{8'h89, 8'h40});
    wpc(24'habcdef);
    start(1'b0, '{8'ha5, 8'h89, 8'h40});
    wpc(24'habcdef);
  endtask : t_ijmp

  // Call then return; the stack is rewritten in between to give distinct bytes.
  task automatic t_ret();
    start(1'b1, '{8'h9a, 8'h00, 8'h01, 8'h00});
    prog[24'h000100] = 8'haa;
    wpc(24'h000101);
    `CHK({dmem[8], dmem[9], dmem[10]}, 24'h000004)
    `CHK(sp_out, ejib_pkg::SP_RST + 16'h0003)
    dmem[8] = 8'h01;
    dmem[9] = 8'h23;
    dmem[10] = 8'h49;
    rd_q.delete();
    wpc(24'h012349);
    `CHK(sp_out, ejib_pkg::SP_RST)
    `CHK({rd_q[0], rd_q[1], rd_q[2]}, 24'h0a0908)
  endtask : t_ret

  // Back-to-back direct increments in both modes, then a prefixed one is refused.
  task automatic t_incd();
    for (int m = 0; m < 2; m++) begin
      dmem[8'h40] = 8'hff;
      dmem[8'h41] = 8'h7e;
      start(1'(m), '{8'h05, 8'h40, 8'h05, 8'h41});
      wpc(24'h000005);
      `CHK({dmem[8'h40], dmem[8'h41]}, 16'h007f)
      `CHK({rmw_q[0], rmw_q[1]}, 2'h3)
    end
    start(1'b0, '{8'ha5, 8'h05, 8'h40});
    wpc(24'h000005);
    `CHK(dmem[8'h40], 8'h00)
    `CHK(ill_n != 0, 1'b1)
  endtask : t_incd

  // All three sizes and immediates; a bad size must leave the byte alone.
  task automatic t_incs();
    wrf(6'h00, 32'h0000_00ff);
    wrf(6'h04, 32'h00fe_0000);
    wrf(6'h08, 32'h0000_ffff);
    start(1'b1, '{8'h0b, 8'h30, 8'h0b, 8'h25, 8'h0b, 8'h2e, 8'h0b, 8'h38});
    wpc(24'h000009);
    rrf(6'h00, 32'h0000_0000);
    rrf(6'h04, 32'h0100_0000);
    rrf(6'h08, 32'h0001_0003);
    `CHK(ill_n != 0, 1'b1)
  endtask : t_incs

  // Data pointer wraps from all ones while the upper word stays put.
  task automatic t_data_pointer_16();
    wrf(ejib_pkg::DPX_IDX, 32'h1234_ffff);
    for (int m = 0; m < 2; m++) begin
      start(1'(m), '{8'ha3});
      wpc(24'h000002);
      rrf(ejib_pkg::DPX_IDX, 32'h1234_0000 + 32'(m));
    end
  endtask : t_data_pointer_16

  // Negative displacement on a set bit, then a clear bit in binary mode.
  task automatic t_jb();
    dmem[8'h20] = 8'h08;
    start(1'b1, '{8'ha9, 8'h23, 8'h20, 8'hf0});
    wpc(24'hfffff4);
    `CHK({dmem[8'h20], wr_n[7:0]}, 16'h0800)
    `CHK(flags_out, 5'h00)
    start(1'b0, '{8'ha5, 8'ha9, 8'h22, 8'h20, 8'h10});
    wpc(24'h000006);
  endtask : t_jb

  // Only the tested bit is cleared; a second pass finds it clear and writes nothing.
  task automatic t_jbc();
    dmem[8'h20] = 8'h0c;
    start(1'b1, '{8'ha9, 8'h12, 8'h20, 8'hf8});
    wpc(24'hfffffc);
    @(negedge clk_sys_in);
    `CHK(dmem[8'h20], 8'h08)
    `CHK(rmw_q[0], 1'b1)
    start(1'b0, '{8'ha5, 8'ha9, 8'h12, 8'h20, 8'hf8});
    wpc(24'h000006);
    `CHK(wr_n, 0)
  endtask : t_jbc

  // Main sequence.
  initial begin
    repeat (16) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    t_jmp();
    t_ijmp();
    t_ret();
    t_incd();
    t_incs();
    t_data_pointer_16();
    t_jb();
    t_jbc();
    end_sim();
  end
endmodule : ejib_core_test
